// File: ccs_cfg.svh
// Constants for the CPU control-state and masking block
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

// Timing, in picoseconds
`define CCS_CLK_PS 25000
`define CCS_CYC0_PS 202500
`define CCS_CYC1_PS 247500
`define CCS_CYC2_PS 292500
`define CCS_CYC3_PS 315000
`define CCS_FETCH_PS 540000

// Program status word bits, bit n of the word sits at index 63-n
`define CCS_PSW_CH0 63
`define CCS_PSW_IO_SUM 57
`define CCS_PSW_EXT 56
`define CCS_PSW_MODE 51
`define CCS_PSW_PROB 48
`define CCS_PSW_CODE_LO 32

// Control register numbers and bits, bit n of the word sits at index 31-n
`define CCS_CR_SUBCLASS 0
`define CCS_CR_CHAN 2
`define CCS_CR0_TIMING 7
`define CCS_CR0_KEY 6
`define CCS_CR0_SIGNAL 5
`define CCS_CR2_CH0 31

// Fixed storage location of the external interruption code
`define CCS_EXT_CODE_ADDR 8'h86

// Reset values
`define CCS_PSW_RST 64'h0
`define CCS_CR_RST 32'h0

`endif

// File: ccs_pkg.sv
// Types for the CPU control-state and masking block
package ccs_pkg;

    typedef enum logic [1:0] {
        CCS_OP_IDLE = 2'b00,
        CCS_OP_RUN = 2'b01
    } ccs_op_st_t;

    typedef enum logic [1:0] {
        CCS_FE_IDLE = 2'b00,
        CCS_FE_WAIT = 2'b01,
        CCS_FE_REISSUE = 2'b10
    } ccs_fe_st_t;

    typedef struct packed {
        logic [1:0] cyc;
        logic [3:0] ra;
        logic [3:0] rb;
        logic [3:0] wa;
        logic [35:0] ucode;
    } ccs_op_req_t;

    typedef struct packed {
        logic ack;
        logic [63:0] data;
        logic [7:0] par;
    } ccs_mem_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [15:0] data;
    } ccs_code_store_t;

endpackage

// File: ccs_ctl.sv
// CPU control registers, mode decode, interruption masking and retry
`timescale 1ns/100ps
`include "ccs_cfg.svh"

// What this block does
// - Operations timed by four selectable cycle lengths
// - Instruction fetch doubleword, data access one word
// - Storage fetch attempt abandoned after fixed fetch time
// - Local store gives two reads per access
// - Parity checked on paths, microwords, adder sums
// - Failed operations retried by hardware automatically
// - Sixteen control registers numbered from zero
// - Each control register is 32 bits
// - Control registers reachable in supervisor state only
// - Load and store instructions move control registers
// - Some control registers act only in extended mode
// - Status word bit 12 selects control mode
// - No ASCII mode, bit 12 means mode
// - Register zero holds three external subclass masks
// - External mask clear blocks all external sources
// - External source taken only if subclass enabled
// - Extended status word drops channel masks, codes
// - Extended mode: masks in register two, codes stored
// - Extended status word uses summary mask bits
// - Facilities not mode dependent behave the same
// - Extended: channel needs summary bit and register two
// - Basic: channel gated by status word bits 0-4
module ccs_ctl #(
    parameter int RETRY_MAX = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psw_load,
    input wire logic [63:0] psw_in,
    input wire logic cr_load,
    input wire logic cr_store,
    input wire logic [3:0] cr_num,
    input wire logic [31:0] cr_wdata,
    output logic [31:0] cr_rdata,
    output logic cr_ack,
    output logic priv_exc,
    output logic extended_mode,
    input wire logic [5:0] ext_src,
    input wire logic [4:0] chan_src,
    output logic ext_take,
    output logic [5:0] ext_which,
    output logic [4:0] chan_take,
    output logic [63:0] old_psw,
    output ccs_pkg::ccs_code_store_t code_store,
    input wire logic op_start,
    input wire ccs_pkg::ccs_op_req_t op_req,
    output logic op_done,
    output logic [31:0] op_sum,
    input wire logic ls_wr,
    input wire logic [3:0] ls_waddr,
    input wire logic [31:0] ls_wdata,
    input wire logic [3:0] ls_wpar,
    input wire logic fetch_start,
    input wire logic fetch_instr,
    output logic mem_req,
    output logic mem_dword,
    input wire ccs_pkg::ccs_mem_rsp_t mem_rsp,
    output logic fetch_done,
    output logic [63:0] fetch_data,
    output logic machine_check
);
    import ccs_pkg::*;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam logic [3:0] CYC0 =
        4'((`CCS_CYC0_PS + `CCS_CLK_PS - 1) / `CCS_CLK_PS);
    localparam logic [3:0] CYC1 =
        4'((`CCS_CYC1_PS + `CCS_CLK_PS - 1) / `CCS_CLK_PS);
    localparam logic [3:0] CYC2 =
        4'((`CCS_CYC2_PS + `CCS_CLK_PS - 1) / `CCS_CLK_PS);
    localparam logic [3:0] CYC3 =
        4'((`CCS_CYC3_PS + `CCS_CLK_PS - 1) / `CCS_CLK_PS);
    localparam logic [4:0] FETCH_MAX = 5'(`CCS_FETCH_PS / `CCS_CLK_PS);
    localparam logic [1:0] RETRIES = 2'(RETRY_MAX);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [63:0] program_status_word;
        logic [15:0][31:0] cr;
        logic [5:0] ext_s1;
        logic [5:0] ext_s2;
        logic [5:0] ext_s3;
        logic [5:0] ext_lvl;
        logic [4:0] ch_s1;
        logic [4:0] ch_s2;
        logic [4:0] ch_s3;
        logic [4:0] ch_lvl;
        logic hold;
        logic ext_take;
        logic [5:0] ext_which;
        logic [4:0] chan_take;
        logic [63:0] old_psw;
        ccs_code_store_t code_store;
        logic [31:0] cr_rdata;
        logic cr_ack;
        logic priv_exc;
        logic [15:0][31:0] ls;
        logic [15:0][3:0] ls_par;
        ccs_op_st_t op_st;
        ccs_op_req_t rq;
        logic [31:0] op_a;
        logic [31:0] op_b;
        logic [3:0] op_pa;
        logic [3:0] op_pb;
        logic [3:0] cnt;
        logic [1:0] tries;
        logic op_done;
        logic [31:0] op_sum;
        ccs_fe_st_t fe_st;
        logic [4:0] fe_cnt;
        logic [1:0] fe_tries;
        logic mem_req;
        logic mem_dword;
        logic fetch_done;
        logic [63:0] fetch_data;
        logic mchk;
    } ccs_state_t;

    localparam ccs_state_t RST = '0;

    ccs_state_t st;
    ccs_state_t next_st;

    // Odd parity per byte
    function automatic logic [3:0] bpar(input logic [31:0] w);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 4; i++) begin
            p[i] = ~^w[8*i +: 8];
        end
        return p;
    endfunction

    // Lowest set bit only
    function automatic logic [5:0] lowest(input logic [5:0] v);
        return v & (~v + 6'h01);
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic xm;
        logic [5:0] sub_en;
        logic [5:0] ext_pend;
        logic [4:0] ch_en;
        logic [4:0] ch_pend;
        logic [3:0] len;
        logic [31:0] sum;
        logic [31:0] carry;
        logic [3:0] pred;
        logic op_ok;
        logic fe_ok;
        logic [5:0] pick;
        xm = 1'b0;
        sub_en = '0;
        ext_pend = '0;
        ch_en = '0;
        ch_pend = '0;
        len = CYC0;
        sum = '0;
        carry = '0;
        pred = '0;
        op_ok = 1'b0;
        fe_ok = 1'b0;
        pick = '0;
        next_st = st;
        next_st.ext_take = 1'b0;
        next_st.chan_take = '0;
        next_st.code_store.valid = 1'b0;
        next_st.cr_ack = 1'b0;
        next_st.priv_exc = 1'b0;
        next_st.op_done = 1'b0;
        next_st.fetch_done = 1'b0;
        next_st.mchk = 1'b0;

        // Pin synchronisers, a change counts once stages two and three agree
        next_st.ext_s1 = ext_src;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_s3 = st.ext_s2;
        next_st.ext_lvl = (st.ext_s2 & st.ext_s3)
            | (st.ext_lvl & (st.ext_s2 | st.ext_s3));
        next_st.ch_s1 = chan_src;
        next_st.ch_s2 = st.ch_s1;
        next_st.ch_s3 = st.ch_s2;
        next_st.ch_lvl = (st.ch_s2 & st.ch_s3)
            | (st.ch_lvl & (st.ch_s2 | st.ch_s3));

        // Mode decode of the current status word
        xm = st.program_status_word[`CCS_PSW_MODE];

        // External masking, same in both modes
        sub_en[0] = st.cr[`CCS_CR_SUBCLASS][`CCS_CR0_KEY];
        sub_en[4:1] = {4{st.cr[`CCS_CR_SUBCLASS][`CCS_CR0_TIMING]}};
        sub_en[5] = st.cr[`CCS_CR_SUBCLASS][`CCS_CR0_SIGNAL];
        ext_pend = st.ext_lvl & sub_en
            & {6{st.program_status_word[`CCS_PSW_EXT]}};

        // Channel masking depends on mode
        for (int i = 0; i < 5; i++) begin
            if (xm) begin
                ch_en[i] = st.program_status_word[`CCS_PSW_IO_SUM]
                    & st.cr[`CCS_CR_CHAN][`CCS_CR2_CH0 - i];
            end else begin
                ch_en[i] = st.program_status_word[`CCS_PSW_CH0 - i];
            end
        end
        ch_pend = st.ch_lvl & ch_en;

        // Status word load releases the interruption hold
        if (psw_load) begin
            next_st.program_status_word = psw_in;
            next_st.hold = 1'b0;
        end

        // Interruption selection, a take sets the hold over any release
        if (!st.hold && |ext_pend) begin
            pick = lowest(ext_pend);
            next_st.ext_take = 1'b1;
            next_st.ext_which = pick;
            next_st.hold = 1'b1;
            if (xm) begin
                next_st.old_psw = st.program_status_word;
                next_st.code_store.valid = 1'b1;
                next_st.code_store.addr = `CCS_EXT_CODE_ADDR;
                next_st.code_store.data = {10'h000, pick};
            end else begin
                next_st.old_psw = st.program_status_word;
                next_st.old_psw[`CCS_PSW_CODE_LO +: 16] = {10'h000, pick};
            end
        end else if (!st.hold && |ch_pend) begin
            pick = lowest({1'b0, ch_pend});
            next_st.chan_take = pick[4:0];
            next_st.hold = 1'b1;
            next_st.old_psw = st.program_status_word;
        end

        // Control register access
        if (cr_load || cr_store) begin
            if (st.program_status_word[`CCS_PSW_PROB]) begin
                next_st.priv_exc = 1'b1;
            end else begin
                next_st.cr_ack = 1'b1;
                if (cr_load) begin
                    next_st.cr[cr_num] = cr_wdata;
                end else begin
                    next_st.cr_rdata = st.cr[cr_num];
                end
            end
        end

        // Local store load port with input path check
        if (ls_wr) begin
            if (bpar(ls_wdata) == ls_wpar) begin
                next_st.ls[ls_waddr] = ls_wdata;
                next_st.ls_par[ls_waddr] = ls_wpar;
            end else begin
                next_st.mchk = 1'b1;
            end
        end

        // Operation sequencer
        case (st.rq.cyc)
            2'h0: len = CYC0;
            2'h1: len = CYC1;
            2'h2: len = CYC2;
            default: len = CYC3;
        endcase
        sum = st.op_a + st.op_b;
        carry = sum ^ st.op_a ^ st.op_b;
        pred = st.op_pa ^ st.op_pb ^ bpar(carry);
        op_ok = (bpar(st.rq.ucode[31:0]) == st.rq.ucode[35:32])
            && (bpar(st.op_a) == st.op_pa) && (bpar(st.op_b) == st.op_pb)
            && (bpar(sum) == pred);
        case (st.op_st)
            CCS_OP_IDLE: begin
                if (op_start) begin
                    next_st.rq = op_req;
                    next_st.op_a = st.ls[op_req.ra];
                    next_st.op_b = st.ls[op_req.rb];
                    next_st.op_pa = st.ls_par[op_req.ra];
                    next_st.op_pb = st.ls_par[op_req.rb];
                    next_st.cnt = '0;
                    next_st.tries = '0;
                    next_st.op_st = CCS_OP_RUN;
                end
            end
            CCS_OP_RUN: begin
                if (st.cnt == len - 4'h1) begin
                    if (op_ok) begin
                        next_st.ls[st.rq.wa] = sum;
                        next_st.ls_par[st.rq.wa] = bpar(sum);
                        next_st.op_sum = sum;
                        next_st.op_done = 1'b1;
                        next_st.op_st = CCS_OP_IDLE;
                    end else if (st.tries < RETRIES) begin
                        next_st.tries = st.tries + 2'h1;
                        next_st.op_a = st.ls[st.rq.ra];
                        next_st.op_b = st.ls[st.rq.rb];
                        next_st.op_pa = st.ls_par[st.rq.ra];
                        next_st.op_pb = st.ls_par[st.rq.rb];
                        next_st.cnt = '0;
                    end else begin
                        next_st.mchk = 1'b1;
                        next_st.op_st = CCS_OP_IDLE;
                    end
                end else begin
                    next_st.cnt = st.cnt + 4'h1;
                end
            end
            default: next_st.op_st = CCS_OP_IDLE;
        endcase

        // Storage fetch sequencer
        fe_ok = st.mem_dword ? (bpar(mem_rsp.data[63:32]) == mem_rsp.par[7:4]
            && bpar(mem_rsp.data[31:0]) == mem_rsp.par[3:0])
            : (bpar(mem_rsp.data[31:0]) == mem_rsp.par[3:0]);
        case (st.fe_st)
            CCS_FE_IDLE: begin
                if (fetch_start) begin
                    next_st.mem_req = 1'b1;
                    next_st.mem_dword = fetch_instr;
                    next_st.fe_cnt = '0;
                    next_st.fe_tries = '0;
                    next_st.fe_st = CCS_FE_WAIT;
                end
            end
            CCS_FE_WAIT: begin
                if (mem_rsp.ack && fe_ok) begin
                    next_st.mem_req = 1'b0;
                    next_st.fetch_done = 1'b1;
                    next_st.fetch_data = st.mem_dword ? mem_rsp.data
                        : {32'h0000_0000, mem_rsp.data[31:0]};
                    next_st.fe_st = CCS_FE_IDLE;
                end else if (mem_rsp.ack || st.fe_cnt == FETCH_MAX - 5'h01) begin
                    next_st.mem_req = 1'b0;
                    if (st.fe_tries < RETRIES) begin
                        next_st.fe_tries = st.fe_tries + 2'h1;
                        next_st.fe_st = CCS_FE_REISSUE;
                    end else begin
                        next_st.mchk = 1'b1;
                        next_st.fe_st = CCS_FE_IDLE;
                    end
                end else begin
                    next_st.fe_cnt = st.fe_cnt + 5'h01;
                end
            end
            CCS_FE_REISSUE: begin
                next_st.mem_req = 1'b1;
                next_st.fe_cnt = '0;
                next_st.fe_st = CCS_FE_WAIT;
            end
            default: next_st.fe_st = CCS_FE_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cr_rdata = st.cr_rdata;
    assign cr_ack = st.cr_ack;
    assign priv_exc = st.priv_exc;
    assign extended_mode = st.program_status_word[`CCS_PSW_MODE];
    assign ext_take = st.ext_take;
    assign ext_which = st.ext_which;
    assign chan_take = st.chan_take;
    assign old_psw = st.old_psw;
    assign code_store = st.code_store;
    assign op_done = st.op_done;
    assign op_sum = st.op_sum;
    assign mem_req = st.mem_req;
    assign mem_dword = st.mem_dword;
    assign fetch_done = st.fetch_done;
    assign fetch_data = st.fetch_data;
    assign machine_check = st.mchk;

endmodule

// File: ccs_mem_model.sv
// Memory responder model facing the fetch port of the control block
`timescale 1ns/100ps
module ccs_mem_model #(
    parameter logic [63:0] DATA = 64'h0123456789abcdef
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mem_req,
    input wire logic [5:0] delay,
    input wire logic [1:0] bad_cnt,
    output ccs_pkg::ccs_mem_rsp_t mem_rsp
);
    import ccs_pkg::*;
    logic [5:0] cnt;
    logic [1:0] bad_used;
    logic done;
    logic [7:0] good_par;
    always_comb begin
        for (int i = 0; i < 8; i++) good_par[i] = ~^DATA[8*i +: 8];
    end
    // One answer per request after the delay, data churns otherwise
    always_ff @(posedge clk) begin
        mem_rsp.ack <= 1'b0;
        mem_rsp.data <= ~mem_rsp.data;
        if (bad_cnt == 2'h0) bad_used <= 2'h0;
        if (sys_rst) begin
            mem_rsp <= '0;
            cnt <= 6'h00;
            done <= 1'b0;
            bad_used <= 2'h0;
        end else if (!mem_req) begin
            cnt <= 6'h00;
            done <= 1'b0;
        end else if (!done) begin
            cnt <= cnt + 6'h01;
            if (cnt == delay) begin
                done <= 1'b1;
                mem_rsp.ack <= 1'b1;
                mem_rsp.data <= DATA;
                mem_rsp.par <= good_par ^ {7'h00, bad_used < bad_cnt};
                if (bad_used < bad_cnt) bad_used <= bad_used + 2'h1;
            end
        end
    end
endmodule

// File: ccs_ctl_chk.sv
// Port checks for the control-state block
`timescale 1ns/100ps
`include "ccs_cfg.svh"
module ccs_ctl_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psw_load,
    input wire logic [63:0] psw_in,
    input wire logic cr_load,
    input wire logic cr_store,
    input wire logic cr_ack,
    input wire logic priv_exc,
    input wire logic extended_mode,
    input wire logic ext_take,
    input wire logic [5:0] ext_which,
    input wire logic [4:0] chan_take,
    input wire ccs_pkg::ccs_code_store_t code_store,
    input wire logic fetch_start,
    input wire logic fetch_instr,
    input wire logic mem_req,
    input wire logic mem_dword,
    input wire logic fetch_done,
    input wire logic machine_check
);
    import ccs_pkg::*;
    logic [63:0] psw_cur;
    logic ch0_en;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        if (sys_rst) psw_cur <= 64'h0;
        else if (psw_load) psw_cur <= psw_in;
    end
    assign ch0_en = psw_cur[`CCS_PSW_MODE] ? psw_cur[`CCS_PSW_IO_SUM]
                                           : psw_cur[`CCS_PSW_CH0];
    sequence s_fetch_go;
        fetch_start && !mem_req ##1 mem_req;
    endsequence
    sequence s_fetch_end;
        ##[1:80] (fetch_done || machine_check);
    endsequence
    priv_refused_a: assert property (
        (cr_load || cr_store) && psw_cur[`CCS_PSW_PROB]
        |=> priv_exc && !cr_ack) else $error("cr access not refused");
    cr_answer_a: assert property (
        (cr_load || cr_store) && !psw_cur[`CCS_PSW_PROB]
        |=> cr_ack && !priv_exc) else $error("cr access not answered");
    mode_follow_a: assert property (
        psw_load |=> extended_mode == $past(psw_in[`CCS_PSW_MODE]))
        else $error("mode bit not followed");
    ext_gate_a: assert property (
        ext_take |-> $past(psw_cur[`CCS_PSW_EXT]))
        else $error("external take while masked");
    chan_gate_a: assert property (
        chan_take[0] |-> $past(ch0_en)) else $error("channel take masked");
    take_single_a: assert property (
        ext_take |-> $onehot(ext_which) && chan_take == 5'h00)
        else $error("external take not single");
    code_when_a: assert property (
        code_store.valid == (ext_take && $past(psw_cur[`CCS_PSW_MODE])))
        else $error("code store in wrong mode");
    code_place_a: assert property (
        code_store.valid |-> code_store.addr == `CCS_EXT_CODE_ADDR
        && code_store.data == {10'h000, ext_which})
        else $error("code store misplaced");
    fetch_size_a: assert property (
        s_fetch_go |-> mem_dword == $past(fetch_instr))
        else $error("fetch size wrong");
    fetch_bound_a: assert property (
        fetch_start && !mem_req |-> s_fetch_end)
        else $error("fetch never ended");
endmodule
bind ccs_ctl ccs_ctl_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .psw_load(psw_load), .psw_in(psw_in), .cr_load(cr_load),
    .cr_store(cr_store), .cr_ack(cr_ack), .priv_exc(priv_exc),
    .extended_mode(extended_mode), .ext_take(ext_take),
    .ext_which(ext_which),
    .chan_take(chan_take), .code_store(code_store),
    .fetch_start(fetch_start), .fetch_instr(fetch_instr),
    .mem_req(mem_req), .mem_dword(mem_dword), .fetch_done(fetch_done),
    .machine_check(machine_check));

// File: ccs_tb.sv
// Testbench for the control-state block
`timescale 1ns/100ps
`include "ccs_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    bad_count++; $display("Error %0t %h %h", $time, a, b); end end
module tb;
    import ccs_pkg::*;
    localparam logic [63:0] DATA = 64'h0123456789abcdef;
    localparam logic [63:0] EXT = 64'h0100000000000000;
    localparam logic [63:0] XCM = 64'h0008000000000000;
    localparam logic [63:0] IOS = 64'h0200000000000000;
    localparam logic [63:0] CH0 = 64'h8000000000000000;
    localparam logic [63:0] PROB = 64'h0001000000000000;
    int bad_count = 0;
    int comparisons = 0;
    int n;
    int lens[4] = '{9, 10, 12, 13};
    logic clk = 1'b0, sys_rst = 1'b1, psw_load = 1'b0, cr_load = 1'b0;
    logic cr_store = 1'b0, ls_wr = 1'b0, op_start = 1'b0;
    logic fetch_start = 1'b0, fetch_instr = 1'b0, hit;
    logic [63:0] psw_in = 64'h0, old_psw, fetch_data;
    logic [3:0] cr_num = 4'h0, ls_waddr = 4'h0, ls_wpar = 4'h0;
    logic [31:0] cr_wdata = 32'h0, ls_wdata = 32'h0, cr_rdata, op_sum;
    logic [5:0] ext_src = 6'h00, mem_dly = 6'h00, ext_which;
    logic [4:0] chan_src = 5'h00, chan_take;
    logic [1:0] bad_cnt = 2'h0;
    logic cr_ack, priv_exc, extended_mode, ext_take, op_done, mem_req;
    logic mem_dword, fetch_done, machine_check;
    ccs_op_req_t op_req = '0;
    ccs_code_store_t code_store;
    ccs_mem_rsp_t mem_rsp;
    always #12.5 clk = ~clk;
    ccs_ctl #(.RETRY_MAX(2)) DUT (.clk(clk), .sys_rst(sys_rst),
        .psw_load(psw_load), .psw_in(psw_in), .cr_load(cr_load),
        .cr_store(cr_store), .cr_num(cr_num), .cr_wdata(cr_wdata),
        .cr_rdata(cr_rdata), .cr_ack(cr_ack), .priv_exc(priv_exc),
        .extended_mode(extended_mode), .ext_src(ext_src),
        .chan_src(chan_src),
        .ext_take(ext_take), .ext_which(ext_which), .chan_take(chan_take),
        .old_psw(old_psw), .code_store(code_store), .op_start(op_start),
        .op_req(op_req), .op_done(op_done), .op_sum(op_sum), .ls_wr(ls_wr),
        .ls_waddr(ls_waddr), .ls_wdata(ls_wdata), .ls_wpar(ls_wpar),
        .fetch_start(fetch_start), .fetch_instr(fetch_instr),
        .mem_req(mem_req), .mem_dword(mem_dword), .mem_rsp(mem_rsp),
        .fetch_done(fetch_done), .fetch_data(fetch_data),
        .machine_check(machine_check));
    ccs_mem_model #(.DATA(DATA)) u_mem (.clk(clk), .sys_rst(sys_rst),
        .mem_req(mem_req), .delay(mem_dly), .bad_cnt(bad_cnt),
        .mem_rsp(mem_rsp));
    function automatic logic [3:0] oddp(input logic [31:0] d);
        for (int i = 0; i < 4; i++) oddp[i] = ~^d[8*i +: 8];
    endfunction
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cr_op(input logic ld, input logic [3:0] k,
            input logic [31:0] d);
        @(posedge clk);
        cr_load <= ld;
        cr_store <= ~ld;
        cr_num <= k;
        cr_wdata <= d;
        @(posedge clk);
        cr_load <= 1'b0;
        cr_store <= 1'b0;
        #1;
    endtask
    task automatic psw_ld(input logic [63:0] v);
        @(posedge clk);
        psw_load <= 1'b1;
        psw_in <= v;
        @(posedge clk);
        psw_load <= 1'b0;
        #1;
        `CHK(extended_mode, v[51])
    endtask
    task automatic irq(input logic [63:0] p, input logic [31:0] c0, c2,
            input logic [5:0] e, input logic [4:0] c, input logic [5:0] xe,
            input logic [4:0] xc);
        cr_op(1'b1, 4'h0, c0);
        cr_op(1'b1, 4'h2, c2);
        psw_ld(p);
        @(posedge clk);
        ext_src <= e;
        chan_src <= c;
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            @(posedge clk);
            #1;
            hit = ext_take | (chan_take != 5'h00);
        end
        `CHK(hit, xe != 6'h00 || xc != 5'h00)
        `CHK(ext_take ? ext_which : 6'h00, xe)
        `CHK(chan_take, xc)
        `CHK(code_store.valid, ext_take & p[51])
        if (ext_take && !p[51]) `CHK(old_psw[47:32], {10'h000, xe})
        if (hit) `CHK(old_psw[63:48], p[63:48])
        @(posedge clk);
        ext_src <= 6'h00;
        chan_src <= 5'h00;
        repeat (6) @(posedge clk);
    endtask
    task automatic ls(input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] pf);
        @(posedge clk);
        ls_wr <= 1'b1;
        ls_waddr <= a;
        ls_wdata <= d;
        ls_wpar <= oddp(d) ^ pf;
        @(posedge clk);
        ls_wr <= 1'b0;
        #1;
        `CHK(machine_check, pf != 4'h0)
    endtask
    task automatic op(input logic [1:0] cy, input logic [3:0] up,
            input int len);
        @(posedge clk);
        op_start <= 1'b1;
        op_req <= '{cy, 4'h1, 4'h2, 4'h3, {up, 32'h0}};
        @(posedge clk);
        op_start <= 1'b0;
        n = 0;
        #1;
        while (!(op_done | machine_check) && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(machine_check, len == 0)
        if (len > 0) `CHK(n, len)
        if (len > 0) `CHK(op_sum, 32'h12346789)
    endtask
    task automatic fetch(input logic ins, input logic [5:0] d,
            input logic [1:0] b, input logic ok);
        @(posedge clk);
        bad_cnt <= 2'h0;
        @(posedge clk);
        bad_cnt <= b;
        mem_dly <= d;
        fetch_start <= 1'b1;
        fetch_instr <= ins;
        @(posedge clk);
        fetch_start <= 1'b0;
        hit = 1'b0;
        for (int i = 0; i < 90 && !hit; i++) begin
            @(posedge clk);
            #1;
            hit = fetch_done | machine_check;
        end
        `CHK(fetch_done, ok)
        `CHK(machine_check, ~ok)
        if (ok) `CHK(fetch_data, ins ? DATA : {32'h0, DATA[31:0]})
    endtask
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            cr_op(1'b1, k[3:0], 32'h01010101 * k);
            `CHK(cr_ack, 1'b1)
        end
        for (int k = 0; k < 16; k++) begin
            cr_op(1'b0, k[3:0], 32'h0);
            `CHK(cr_rdata, 32'h01010101 * k)
        end
        psw_ld(PROB);
        cr_op(1'b1, 4'h5, 32'hffffffff);
        `CHK(priv_exc, 1'b1)
        psw_ld(64'h0);
        cr_op(1'b0, 4'h5, 32'h0);
        `CHK(cr_rdata, 32'h05050505)
        $display("test control registers done");
        irq(EXT | CH0, 32'h40, 32'h0, 6'h01, 5'h01, 6'h01, 5'h00);
        irq(CH0, 32'he0, 32'h0, 6'h01, 5'h00, 6'h00, 5'h00);
        irq(EXT, 32'h80, 32'h0, 6'h01, 5'h00, 6'h00, 5'h00);
        irq(EXT, 32'h80, 32'h0, 6'h08, 5'h00, 6'h08, 5'h00);
        irq(EXT | XCM, 32'h80, 32'h0, 6'h10, 5'h00, 6'h10, 5'h00);
        irq(EXT | XCM, 32'h60, 32'h0, 6'h21, 5'h00, 6'h01, 5'h00);
        irq(CH0, 32'h0, 32'h0, 6'h00, 5'h01, 6'h00, 5'h01);
        irq(64'h0, 32'h0, 32'hffffffff, 6'h00, 5'h01, 6'h00, 5'h00);
        irq(XCM | CH0, 32'h0, 32'hffffffff, 6'h00, 5'h01, 6'h00, 5'h00);
        irq(XCM | IOS, 32'h0, 32'h20000000, 6'h00, 5'h04, 6'h00, 5'h04);
        $display("test interruptions done");
        ls(4'h1, 32'h12345678, 4'h0);
        ls(4'h2, 32'h00001111, 4'h0);
        ls(4'h4, 32'h0, 4'h1);
        for (int k = 0; k < 4; k++) op(k[1:0], 4'hf, lens[k]);
        op(2'h0, 4'h0, 0);
        $display("test operations done");
        fetch(1'b1, 6'h00, 2'h0, 1'b1);
        fetch(1'b0, 6'h05, 2'h0, 1'b1);
        fetch(1'b1, 6'h02, 2'h2, 1'b1);
        fetch(1'b1, 6'h01, 2'h3, 1'b0);
        fetch(1'b0, 6'h3f, 2'h0, 1'b0);
        $display("test fetches done");
        finish_test();
    end
endmodule
